// File: slave_port_consts.svh
// register offsets, field positions, reset values and timing constants for the slave port
`ifndef SLAVE_PORT_CONSTS_SVH
`define SLAVE_PORT_CONSTS_SVH

`define OFS_DATA_LATCH      8'h08
`define OFS_CTRL_PORT       8'h09
`define OFS_IRQ_FLAGS       8'h0c
`define OFS_STATUS_DIR      8'h89
`define OFS_IRQ_ENABLES     8'h8c
`define OFS_ANALOG_CFG      8'h9f

`define BIT_INPUT_FULL      7
`define BIT_OUTPUT_FULL     6
`define BIT_INPUT_OVERRUN   5
`define BIT_PORT_ENABLE     4
`define BIT_SLAVE_IRQ       7

`define RST_STATUS_DIR      8'h07
`define RST_ZERO8           8'h00
`define RST_DIR3            3'h7
`define ANALOG_FIELD_W      4
`define PHASE_COUNT         2'h3
`define PHASE_TWO           2'h1
`define PHASE_FOUR          2'h3

`endif

// File: slave_port_pkg.sv
// types shared by the slave port design
package slave_port_pkg;
  typedef enum logic [2:0] {
    XFER_IDLE = 3'b001,
    XFER_WAIT = 3'b010,
    XFER_DONE = 3'b100
  } end_state_t;
endpackage : slave_port_pkg

// File: slave_port_sync.sv
// two-flop synchroniser for the host strobes and chip select
module slave_port_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) begin
      $error("width must be positive");
    end
  end

  // inputs idle high, so reset to ones avoids a fake transfer at release
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else if (clk_en_in) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : slave_port_sync

// File: parallel_slave_port.sv
// parallel slave port: host strobes, data latches, status flags and register file
`include "slave_port_consts.svh"

// Function
// - enable bit turns pins into slave strobes
// - read strobe and select low drive data
// - write strobe and select low latch data
// - deselected device ignores both strobes
// - separate input and output latches, one address
// - direction register ignored, drive only on reads
// - write starts when select and strobe low
// - input full set phase four after two
// - irq flag set with input full
// - only cpu read of latch clears full in mode
// - second write before read sets overrun
// - output full cleared at read start
// - read end sets irq flag phase four
// - output full stays low until cpu write
// - flags clear outside mode, overrun kept
// - full flags read-only, overrun software cleared
// - irq flag sticky, raises irq when enabled
// - direction bits one input, reset to one
// - software sets inputs and digital config
module parallel_slave_port #(
  parameter int DATA_W = 8
) (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              clk_en_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_write_in,
  input  wire logic              reg_read_in,
  output logic      [7:0]        reg_rdata_out,
  input  wire logic              host_rd_n_in,
  input  wire logic              host_wr_n_in,
  input  wire logic              host_cs_n_in,
  input  wire logic [DATA_W-1:0] data_pins_in,
  output logic      [DATA_W-1:0] data_pins_out,
  output logic                   data_pins_oe_out,
  output logic                   slave_port_irq_out
);
  initial begin
    if (DATA_W != 8) begin
      $error("slave port data width must be 8");
    end
  end

  logic [2:0]        strobes_s;
  logic [DATA_W-1:0] out_latch_q;
  logic [DATA_W-1:0] in_latch_q;
  logic              input_full_q;
  logic              output_full_q;
  logic              overrun_q;
  logic              port_enable_q;
  logic [2:0]        dir_q;
  logic [7:0]        irq_flags_q;
  logic [7:0]        irq_enables_q;
  logic [7:0]        analog_cfg_q;
  logic [1:0]        phase_q;
  logic              wr_active_q;
  logic              rd_active_q;
  logic              data_oe_q;
  slave_port_pkg::end_state_t wr_state_q;
  slave_port_pkg::end_state_t wr_state_d;
  slave_port_pkg::end_state_t rd_state_q;
  slave_port_pkg::end_state_t rd_state_d;
  logic [DATA_W-1:0] data_s;

  // meta-hardened copies of the host control pins
  slave_port_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({host_cs_n_in, host_wr_n_in, host_rd_n_in}),
    .sync_out   (strobes_s)
  );

  // data pins take the same two-flop path as the strobes, so the latch never
  // samples a bus that the host has already released; costs two cycles of lag
  slave_port_sync #(
    .WIDTH (DATA_W)
  ) u_data_sync (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   (data_pins_in),
    .sync_out   (data_s)
  );

  // address decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  wire sel_data    = hit(reg_addr_in, `OFS_DATA_LATCH);
  wire sel_ctrl    = hit(reg_addr_in, `OFS_CTRL_PORT);
  wire sel_flags   = hit(reg_addr_in, `OFS_IRQ_FLAGS);
  wire sel_status  = hit(reg_addr_in, `OFS_STATUS_DIR);
  wire sel_enables = hit(reg_addr_in, `OFS_IRQ_ENABLES);
  wire sel_analog  = hit(reg_addr_in, `OFS_ANALOG_CFG);

  // strobes only count when the mode is on and the chip is selected
  wire cs_low    = port_enable_q && !strobes_s[2];
  wire wr_low    = cs_low && !strobes_s[1];
  wire rd_low    = cs_low && !strobes_s[0];
  wire wr_start  = wr_low && !wr_active_q;
  wire rd_start  = rd_low && !rd_active_q;
  wire wr_end    = wr_active_q && !wr_low;
  wire rd_end    = rd_active_q && !rd_low;
  wire at_two    = (phase_q == `PHASE_TWO);
  wire at_four   = (phase_q == `PHASE_FOUR);
  wire wr_finish = (wr_state_q == slave_port_pkg::XFER_DONE) && at_four;
  wire rd_finish = (rd_state_q == slave_port_pkg::XFER_DONE) && at_four;
  wire cpu_rd_in = reg_read_in && sel_data;
  wire cpu_wr_out = reg_write_in && sel_data;

  // end-of-transfer sequencers: wait for phase two, then fire on phase four
  function automatic slave_port_pkg::end_state_t step(
    input slave_port_pkg::end_state_t st, input logic ended, input logic two);
    case (st)
      slave_port_pkg::XFER_IDLE: step = ended ? slave_port_pkg::XFER_WAIT : st;
      slave_port_pkg::XFER_WAIT: step = two ? slave_port_pkg::XFER_DONE : st;
      slave_port_pkg::XFER_DONE: step = slave_port_pkg::XFER_IDLE;
      default:                   step = slave_port_pkg::XFER_IDLE;
    endcase
  endfunction : step

  // phase four only counts once reached; otherwise hold in done
  always_comb begin
    wr_state_d = step(wr_state_q, wr_end, at_two);
    if (wr_state_q == slave_port_pkg::XFER_DONE && !at_four) begin
      wr_state_d = wr_state_q;
    end
    rd_state_d = step(rd_state_q, rd_end, at_two);
    if (rd_state_q == slave_port_pkg::XFER_DONE && !at_four) begin
      rd_state_d = rd_state_q;
    end
  end

  // read mux; unmapped addresses read zero
  wire [7:0] status_word = {input_full_q, output_full_q, overrun_q, port_enable_q, 1'b0, dir_q};
  wire [7:0] ctrl_word   = {5'h00, host_cs_n_in, host_wr_n_in, host_rd_n_in};
  wire [7:0] rd_mux =
    sel_data    ? (port_enable_q ? in_latch_q : data_pins_in) :
    sel_ctrl    ? ctrl_word :
    sel_flags   ? irq_flags_q :
    sel_status  ? status_word :
    sel_enables ? irq_enables_q :
    sel_analog  ? analog_cfg_q : 8'h00;

  // instruction phase counter and transfer-active trackers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q     <= 2'h0;
      wr_active_q <= 1'b0;
      rd_active_q <= 1'b0;
      wr_state_q  <= slave_port_pkg::XFER_IDLE;
      rd_state_q  <= slave_port_pkg::XFER_IDLE;
    end else if (clk_en_in) begin
      phase_q     <= (phase_q == `PHASE_COUNT) ? 2'h0 : phase_q + 2'h1;
      wr_active_q <= wr_low;
      rd_active_q <= rd_low;
      wr_state_q  <= wr_state_d;
      rd_state_q  <= rd_state_d;
    end
  end

  // host-side data latch and pin driver
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_latch_q    <= `RST_ZERO8;
      data_oe_q     <= 1'b0;
      data_pins_out <= `RST_ZERO8;
    end else if (clk_en_in) begin
      if (wr_low) begin
        in_latch_q <= data_s;
      end
      // direction register is not consulted in slave mode
      data_oe_q     <= rd_low;
      data_pins_out <= out_latch_q;
    end
  end
  assign data_pins_oe_out = data_oe_q;

  // status flags; hardware set beats software clear
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      input_full_q  <= 1'b0;
      output_full_q <= 1'b0;
      overrun_q     <= 1'b0;
    end else if (clk_en_in) begin
      if (!port_enable_q) begin
        input_full_q  <= 1'b0;
        output_full_q <= 1'b0;
      end else begin
        if (wr_finish) begin
          input_full_q <= 1'b1;
        end else if (cpu_rd_in) begin
          input_full_q <= 1'b0;
        end
        if (rd_start) begin
          output_full_q <= 1'b0;
        end else if (cpu_wr_out) begin
          output_full_q <= 1'b1;
        end
      end
      if (wr_finish && input_full_q && !cpu_rd_in) begin
        overrun_q <= 1'b1;
      end else if (reg_write_in && sel_status) begin
        overrun_q <= reg_wdata_in[`BIT_INPUT_OVERRUN];
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      out_latch_q   <= `RST_ZERO8;
      port_enable_q <= 1'b0;
      dir_q         <= `RST_DIR3;
      irq_enables_q <= `RST_ZERO8;
      analog_cfg_q  <= `RST_ZERO8;
    end else if (clk_en_in && reg_write_in) begin
      if (sel_data) begin
        out_latch_q <= reg_wdata_in;
      end
      if (sel_status) begin
        port_enable_q <= reg_wdata_in[`BIT_PORT_ENABLE];
        dir_q         <= reg_wdata_in[2:0];
      end
      if (sel_enables) begin
        irq_enables_q <= reg_wdata_in;
      end
      if (sel_analog) begin
        analog_cfg_q <= reg_wdata_in;
      end
    end
  end

  // interrupt flag register: the slave bit is sticky, set wins
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_flags_q <= `RST_ZERO8;
    end else if (clk_en_in) begin
      if (reg_write_in && sel_flags) begin
        irq_flags_q <= reg_wdata_in;
      end
      if (wr_finish || rd_finish) begin
        irq_flags_q[`BIT_SLAVE_IRQ] <= 1'b1;
      end
    end
  end

  // irq output and read data, both registered
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      slave_port_irq_out <= 1'b0;
      reg_rdata_out      <= `RST_ZERO8;
    end else if (clk_en_in) begin
      slave_port_irq_out <= irq_flags_q[`BIT_SLAVE_IRQ] && irq_enables_q[`BIT_SLAVE_IRQ];
      reg_rdata_out      <= reg_read_in ? rd_mux : `RST_ZERO8;
    end
  end

  // assertions
  property p_wr_full;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      clk_en_in && wr_finish && port_enable_q |=> input_full_q;
  endproperty
  a_wr_full: assert property (p_wr_full) else $error("input full not set");

  property p_wr_irq;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      clk_en_in && wr_finish |=> irq_flags_q[`BIT_SLAVE_IRQ];
  endproperty
  a_wr_irq: assert property (p_wr_irq) else $error("irq flag not set on write");

  property p_rd_obf;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      clk_en_in && rd_start |=> !output_full_q;
  endproperty
  a_rd_obf: assert property (p_rd_obf) else $error("output full not cleared");

  property p_off_clear;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      !port_enable_q && clk_en_in |=> !input_full_q && !output_full_q;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("flags not held clear");

  property p_oe_only_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $past(clk_en_in) && data_pins_oe_out |-> $past(rd_low);
  endproperty
  a_oe_only_read: assert property (p_oe_only_read) else $error("pins driven outside read");

  property p_finish_phase;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(input_full_q) |-> $past(phase_q) == `PHASE_FOUR;
  endproperty
  a_finish_phase: assert property (p_finish_phase) else $error("full set off phase four");

  sequence s_write_end;
    clk_en_in && wr_end;
  endsequence
  property p_end_bound;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_write_end ##0 clk_en_in[*8] |-> ##[0:8] (wr_state_q == slave_port_pkg::XFER_IDLE);
  endproperty
  a_end_bound: assert property (p_end_bound) else $error("write end not finished");

  property p_irq_out;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      clk_en_in && irq_flags_q[`BIT_SLAVE_IRQ] && irq_enables_q[`BIT_SLAVE_IRQ]
      |=> slave_port_irq_out;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq not raised");

  // a finished host read must leave the sticky flag set
  property p_rd_irq;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      clk_en_in && rd_finish |=> irq_flags_q[`BIT_SLAVE_IRQ];
  endproperty
  a_rd_irq: assert property (p_rd_irq) else $error("irq flag not set on read");

  // input full may only drop after a cpu read or with the mode off
  property p_full_clear_src;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(input_full_q) |-> $past(cpu_rd_in) || !$past(port_enable_q);
  endproperty
  a_full_clear_src: assert property (p_full_clear_src) else $error("input full dropped");

  // output full may only rise after a cpu write of the latch
  property p_obf_set_src;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(output_full_q) |-> $past(cpu_wr_out);
  endproperty
  a_obf_set_src: assert property (p_obf_set_src) else $error("output full rose alone");

  // overrun rises only from a write onto a full latch or from software
  property p_ovr_src;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(overrun_q) |->
        ($past(wr_finish) && $past(input_full_q)) || ($past(reg_write_in) && $past(sel_status));
  endproperty
  a_ovr_src: assert property (p_ovr_src) else $error("overrun rose alone");
endmodule : parallel_slave_port

// File: host_model.sv
// behavioural external host that drives the slave port strobes and data bus
module host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] dev_data_in,
  input  wire logic       dev_oe_in,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic            cs_n_out,
  output logic [7:0]      bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drive_q;
  logic       drive_en_q;
  logic [7:0] last_q;

  // undriven bus shows a changing pattern so a stale value never looks right
  assign bus_out = dev_oe_in ? dev_data_in : (drive_en_q ? drive_q : ~last_q);

  always @(posedge clk_in) last_q <= bus_out;

  // strobes and select idle high
  initial begin
    rd_n_out   = 1'b1;
    wr_n_out   = 1'b1;
    cs_n_out   = 1'b1;
    drive_en_q = 1'b0;
    drive_q    = 8'h00;
    last_q     = 8'h00;
  end

  // write: data held with the strobe, sel low leaves the device deselected
  task automatic write_byte(input logic [7:0] v, input logic sel, input int hold);
    @(posedge clk_in);
    cs_n_out   <= ~sel;
    wr_n_out   <= 1'b0;
    drive_q    <= v;
    drive_en_q <= 1'b1;
    repeat (hold) @(posedge clk_in);
    cs_n_out   <= 1'b1;
    wr_n_out   <= 1'b1;
    drive_en_q <= 1'b0;
  endtask : write_byte

  // read: sample what the device puts on the bus at the end of the strobe
  task automatic read_byte(output logic [7:0] v, output logic oe, input logic sel,
                           input int hold);
    @(posedge clk_in);
    cs_n_out <= ~sel;
    rd_n_out <= 1'b0;
    repeat (hold) @(posedge clk_in);
    v        = dev_data_in;
    oe       = dev_oe_in;
    cs_n_out <= 1'b1;
    rd_n_out <= 1'b1;
  endtask : read_byte
endmodule : host_model

// File: tb.sv
// self-checking bench for the parallel slave port
`include "slave_port_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk_in   = 1'b0;
  logic       rst_n_in     = 1'b0;
  logic [7:0] reg_addr_in  = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       reg_write_in = 1'b0;
  logic       reg_read_in  = 1'b0;
  logic       clk_en       = 1'b1;
  logic [7:0] reg_rdata_out;
  logic [7:0] bus;
  logic [7:0] dev_out;
  logic       rd_n, wr_n, cs_n, oe, irq, seen_oe;
  logic [7:0] v;
  int         err_total = 0;
  int         tests_run = 0;
  int         cycles    = 0;

  always #10 ref_clk_in = ~ref_clk_in;

  parallel_slave_port uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .host_rd_n_in(rd_n),
    .host_wr_n_in(wr_n), .host_cs_n_in(cs_n), .data_pins_in(bus), .data_pins_out(dev_out),
    .data_pins_oe_out(oe), .slave_port_irq_out(irq));

  host_model host (.clk_in(ref_clk_in), .dev_data_in(dev_out), .dev_oe_in(oe),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .cs_n_out(cs_n), .bus_out(bus));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_read_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_write_in <= 1'b0;
  endtask : wr

  task automatic rk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask : rk

  // let the synchroniser and the phase sequencer finish
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : settle

  task automatic t_regs;
    rk("status", `OFS_STATUS_DIR, `RST_STATUS_DIR);
    rk("flags", `OFS_IRQ_FLAGS, `RST_ZERO8);
    rk("enables", `OFS_IRQ_ENABLES, `RST_ZERO8);
    rk("analog", `OFS_ANALOG_CFG, `RST_ZERO8);
    rk("ctrl_idle", `OFS_CTRL_PORT, 8'h07);
    wr(8'h88, 8'hff);
    rk("unmapped", 8'h88, 8'h00);
    wr(`OFS_STATUS_DIR, 8'hc8);
    rk("status_ro", `OFS_STATUS_DIR, 8'h00);
    wr(`OFS_ANALOG_CFG, 8'h06);
    rk("analog_rw", `OFS_ANALOG_CFG, 8'h06);
    wr(`OFS_STATUS_DIR, 8'h17);
    rk("mode_on", `OFS_STATUS_DIR, 8'h17);
    $display("test regs done");
  endtask : t_regs

  // a write while the clock enable is low must not land
  task automatic t_freeze;
    @(posedge ref_clk_in);
    clk_en <= 1'b0;
    wr(`OFS_IRQ_ENABLES, 8'h80);
    @(posedge ref_clk_in);
    clk_en <= 1'b1;
    rk("frozen_wr", `OFS_IRQ_ENABLES, 8'h00);
    $display("test freeze done");
  endtask : t_freeze

  task automatic t_write;
    host.write_byte(8'ha5, 1'b1, 4);
    rk("full_early", `OFS_STATUS_DIR, 8'h17);
    settle(10);
    rk("full_set", `OFS_STATUS_DIR, 8'h97);
    rk("full_kept", `OFS_STATUS_DIR, 8'h97);
    rk("irq_flag", `OFS_IRQ_FLAGS, 8'h80);
    chk("irq_masked", {7'h00, irq}, 8'h00);
    wr(`OFS_IRQ_ENABLES, 8'h80);
    settle(2);
    chk("irq_on", {7'h00, irq}, 8'h01);
    rk("in_latch", `OFS_DATA_LATCH, 8'ha5);
    rk("full_clr", `OFS_STATUS_DIR, 8'h17);
    wr(`OFS_IRQ_FLAGS, 8'h00);
    settle(2);
    chk("irq_off", {7'h00, irq}, 8'h00);
    $display("test write done");
  endtask : t_write

  task automatic t_overrun;
    host.write_byte(8'h11, 1'b1, 4);
    settle(10);
    host.write_byte(8'h22, 1'b1, 9);
    settle(10);
    rk("ovr_set", `OFS_STATUS_DIR, 8'hb7);
    rd(`OFS_DATA_LATCH, v);
    chk("ovr_data", v, 8'h22);
    rk("ovr_kept", `OFS_STATUS_DIR, 8'h37);
    wr(`OFS_STATUS_DIR, 8'h17);
    rk("ovr_clr", `OFS_STATUS_DIR, 8'h17);
    wr(`OFS_IRQ_FLAGS, 8'h00);
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_read;
    wr(`OFS_DATA_LATCH, 8'h3c);
    rk("obf_set", `OFS_STATUS_DIR, 8'h57);
    host.read_byte(v, seen_oe, 1'b1, 5);
    chk("host_data", v, 8'h3c);
    chk("host_oe", {7'h00, seen_oe}, 8'h01);
    settle(10);
    chk("oe_idle", {7'h00, oe}, 8'h00);
    rk("obf_clr", `OFS_STATUS_DIR, 8'h17);
    rk("rd_irq", `OFS_IRQ_FLAGS, 8'h80);
    wr(`OFS_IRQ_FLAGS, 8'h00);
    $display("test read done");
  endtask : t_read

  task automatic t_deselect;
    host.write_byte(8'h5a, 1'b0, 4);
    settle(10);
    rk("desel_full", `OFS_STATUS_DIR, 8'h17);
    host.read_byte(v, seen_oe, 1'b0, 5);
    chk("desel_oe", {7'h00, seen_oe}, 8'h00);
    rk("desel_irq", `OFS_IRQ_FLAGS, 8'h00);
    wr(`OFS_DATA_LATCH, 8'h01);
    wr(`OFS_STATUS_DIR, 8'h27);
    rk("mode_off", `OFS_STATUS_DIR, 8'h27);
    host.write_byte(8'h77, 1'b1, 4);
    settle(10);
    rk("off_write", `OFS_STATUS_DIR, 8'h27);
    rk("off_irq", `OFS_IRQ_FLAGS, 8'h00);
    wr(`OFS_STATUS_DIR, 8'h07);
    rk("ovr_sw", `OFS_STATUS_DIR, 8'h07);
    $display("test deselect done");
  endtask : t_deselect

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end

  initial begin
    repeat (20) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_freeze();
    t_write();
    t_overrun();
    t_read();
    t_deselect();
    results();
  end
endmodule : tb
